// [logic/apdc_pkg.sv]
// Register map, field layout and control carrier of the configuration bank.
// Summary of operation
// RULE1: Current-sense off bit set disables sensing
// RULE2: Boost off at bit 3 forces battery supply
// RULE3: Amplifier off at bit 2 stops amp and DAC
// RULE4: Bit 1 set restricts stage to battery rail
// RULE5: Master power-down bit 0, resets set, idles all
// RULE6: Sense rate field [5:4] divides DAC rate
// RULE7: Sense high-pass bit 3, resets on
// RULE8: Edge-rate bit 2 selects low-EMI slow edge_rate_select
// RULE9: Gain bit 0 selects 3.6 or 5.2 V
// RULE10: DAC high-pass bit resets on, filters input
// RULE11: Low-power bit picks 64 or 128 fs
// RULE12: Rate range [2:0] resets 010, reserved refused
// RULE13: Hard-volume bit 7 skips soft volume ramp
// RULE14: Mute bit 6 silences DAC output
package apdc_pkg;

   // ---------------------------------------------------------------
   // Register offsets and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] APDC_OFS_POWER = 8'h00;
   localparam logic [7:0] APDC_OFS_AMP   = 8'h01;
   localparam logic [7:0] APDC_OFS_DAC   = 8'h02;
   localparam logic [7:0] APDC_RST_POWER = 8'h81;
   localparam logic [7:0] APDC_RST_AMP   = 8'h09;
   localparam logic [7:0] APDC_RST_DAC   = 8'h32;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int APDC_PWR_ISNS   = 4;
   localparam int APDC_PWR_BOOST  = 3;
   localparam int APDC_PWR_AMP    = 2;
   localparam int APDC_PWR_BATT   = 1;
   localparam int APDC_PWR_MASTER_SOFT_POWERDOWN  = 0;
   localparam int APDC_AMP_DIV_LO = 4;
   localparam int APDC_AMP_HPF    = 3;
   localparam int APDC_AMP_EDGE   = 2;
   localparam int APDC_AMP_GAIN   = 0;
   localparam int APDC_IMMEDIATE_VOLUME_CHANGE     = 7;
   localparam int APDC_DAC_MUTE   = 6;
   localparam int APDC_CONVERTER_HIGHPASS_ENABLE    = 5;
   localparam int APDC_CONVERTER_LOW_POWER    = 4;
   localparam int APDC_DAC_RATE_LO = 0;
   localparam logic [2:0] APDC_RATE_MAX = 3'h4;

   // ---------------------------------------------------------------
   // Control carrier to the analog and datapath blocks
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       current_sense_en;
      logic       boost_en;
      logic       amp_dac_en;
      logic       battery_only;
      logic       five_level_en;
      logic       sense_hpf_en;
      logic       low_emi_edge_rate_select;
      logic       gain_5v2;
      logic       hard_volume;
      logic       dac_mute;
      logic       converter_highpass_enable_en;
      logic       mod_64fs;
      logic [2:0] rate_range;
      logic [1:0] sense_div;
   } apdc_ctrl_s;

endpackage : apdc_pkg

// [logic/apdc_regs.sv]
// Power, amplifier/sense and DAC configuration registers with control map.
`timescale 1ns/1ps
`default_nettype none
module apdc_regs
   import apdc_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic [7:0]      reg_rdata_o,
   output logic            reg_rvalid_o,
   input  wire logic       dac_sample_i,
   output logic            sense_sample_o,
   output apdc_ctrl_s      ctrl_o
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [7:0] power_down_control_r;
   logic [7:0] amplifier_sense_config_r;
   logic [7:0] converter_playback_config_r;
   logic [7:0] rdata_r;
   logic       rvalid_r;
   apdc_ctrl_s ctrl_r;
   apdc_ctrl_s ctrl_nxt;

   logic       wr_power;
   logic       wr_amp;
   logic       wr_dac;
   logic [2:0] new_rate;

   // Control-port address decode
   always_comb begin
      wr_power = 1'b0;
      wr_amp   = 1'b0;
      wr_dac   = 1'b0;
      if (reg_addr_i == APDC_OFS_POWER) begin
         wr_power = reg_wr_i;
      end else if (reg_addr_i == APDC_OFS_AMP) begin
         wr_amp = reg_wr_i;
      end else if (reg_addr_i == APDC_OFS_DAC) begin
         wr_dac = reg_wr_i;
      end
   end

   assign new_rate = reg_wdata_i[APDC_DAC_RATE_LO +: 3];

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // Upper power bits are only stored here; their logic lives elsewhere
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         power_down_control_r <= APDC_RST_POWER; // RULE5
      end else if (wr_power) begin
         power_down_control_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         amplifier_sense_config_r <= APDC_RST_AMP; // RULE7
      end else if (wr_amp) begin
         amplifier_sense_config_r <= reg_wdata_i;
      end
   end

   // Reserved rate codes would leave the clocking undefined: keep old code
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         converter_playback_config_r <= APDC_RST_DAC; // RULE10
      end else if (wr_dac) begin
         converter_playback_config_r[7:3] <= reg_wdata_i[7:3];
         if (new_rate <= APDC_RATE_MAX) begin
            converter_playback_config_r[2:0] <= new_rate; // RULE12
         end
      end
   end

   // ---------------------------------------------------------------
   // Read path: unmapped offsets read as zero
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd_i;
         if (!reg_rd_i) begin
            rdata_r <= 8'h00;
         end else if (reg_addr_i == APDC_OFS_POWER) begin
            rdata_r <= power_down_control_r;
         end else if (reg_addr_i == APDC_OFS_AMP) begin
            rdata_r <= amplifier_sense_config_r;
         end else if (reg_addr_i == APDC_OFS_DAC) begin
            rdata_r <= converter_playback_config_r;
         end else begin
            rdata_r <= 8'h00;
         end
      end
   end

   assign reg_rdata_o  = rdata_r;
   assign reg_rvalid_o = rvalid_r;

   // ---------------------------------------------------------------
   // Control mapping
   // ---------------------------------------------------------------
   function automatic apdc_ctrl_s map_ctrl(input logic [7:0] p,
                                           input logic [7:0] a,
                                           input logic [7:0] d);
      apdc_ctrl_s c;
      logic       run;
      run = !p[APDC_PWR_MASTER_SOFT_POWERDOWN]; // RULE5
      c.current_sense_en = run && !p[APDC_PWR_ISNS]; // RULE1
      c.boost_en         = run && !p[APDC_PWR_BOOST]; // RULE2
      c.amp_dac_en       = run && !p[APDC_PWR_AMP]; // RULE3
      // No boosted rail exists while boost is off or idle
      c.battery_only     = p[APDC_PWR_BATT] || !c.boost_en; // RULE4 RULE2
      c.five_level_en    = !c.battery_only; // RULE4
      c.sense_hpf_en     = a[APDC_AMP_HPF]; // RULE7
      c.low_emi_edge_rate_select    = a[APDC_AMP_EDGE]; // RULE8
      c.gain_5v2         = a[APDC_AMP_GAIN]; // RULE9
      c.sense_div        = a[APDC_AMP_DIV_LO +: 2]; // RULE6
      c.hard_volume      = d[APDC_IMMEDIATE_VOLUME_CHANGE]; // RULE13
      c.dac_mute         = d[APDC_DAC_MUTE]; // RULE14
      c.converter_highpass_enable_en       = d[APDC_CONVERTER_HIGHPASS_ENABLE]; // RULE10
      c.mod_64fs         = d[APDC_CONVERTER_LOW_POWER]; // RULE11
      c.rate_range       = d[APDC_DAC_RATE_LO +: 3]; // RULE12
      return c;
   endfunction : map_ctrl

   assign ctrl_nxt = map_ctrl(power_down_control_r, amplifier_sense_config_r,
                              converter_playback_config_r);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ctrl_r <= map_ctrl(APDC_RST_POWER, APDC_RST_AMP, APDC_RST_DAC);
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign ctrl_o = ctrl_r;

   // ---------------------------------------------------------------
   // Sense sample rate
   // ---------------------------------------------------------------
   apdc_sense_rate #(
      .CNT_W          (3)
   ) u_sense_rate (
      .clock_i        (clock_i),
      .rst_i          (rst_i),
      .enable_i       (ctrl_r.current_sense_en),
      .dac_sample_i   (dac_sample_i),
      .div_i          (ctrl_r.sense_div),
      .sense_sample_o (sense_sample_o)
   );

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   logic [3:0] samp_gap_r;
   always_ff @(posedge clock_i) begin
      if (rst_i || sense_sample_o || !ctrl_r.current_sense_en) begin
         samp_gap_r <= 4'h0;
      end else if (dac_sample_i && samp_gap_r != 4'hf) begin
         samp_gap_r <= samp_gap_r + 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // Power controls
   // ---------------------------------------------------------------
   a_isns_write_off: assert property ( // RULE1
      (wr_power && reg_wdata_i[APDC_PWR_ISNS]) |-> ##2
         !ctrl_o.current_sense_en)
      else $error("current sense still on after off write");
   a_boost_battery: assert property ( // RULE2
      (wr_power && reg_wdata_i[APDC_PWR_BOOST]) |-> ##2
         (!ctrl_o.boost_en && ctrl_o.battery_only))
      else $error("boost off did not force battery supply");
   a_amp_dac_off: assert property ( // RULE3
      (wr_power && reg_wdata_i[APDC_PWR_AMP]) |-> ##2
         !ctrl_o.amp_dac_en)
      else $error("amplifier still on after off write");
   a_batt_only_lvl: assert property ( // RULE4
      ctrl_o.five_level_en |-> !ctrl_o.battery_only
         && $past(!power_down_control_r[APDC_PWR_BATT]))
      else $error("five-level output with battery-only set");
   a_batt_only_set: assert property ( // RULE4
      $past(power_down_control_r[APDC_PWR_BATT]) |->
         (ctrl_o.battery_only && !ctrl_o.five_level_en))
      else $error("battery-only bit ignored");
   a_master_pd_idle: assert property ( // RULE5
      $past(power_down_control_r[APDC_PWR_MASTER_SOFT_POWERDOWN]) |->
         !(ctrl_o.current_sense_en || ctrl_o.boost_en
           || ctrl_o.amp_dac_en))
      else $error("block active during master power-down");

   // ---------------------------------------------------------------
   // State one edge after reset
   // ---------------------------------------------------------------
   a_reset_values: assert property ( // RULE5 RULE7 RULE10 RULE12
      $past(rst_i) |-> (power_down_control_r == APDC_RST_POWER
         && amplifier_sense_config_r == APDC_RST_AMP
         && converter_playback_config_r == APDC_RST_DAC))
      else $error("register not at reset value after reset");
   a_reset_ctrl: assert property ( // RULE9 RULE11
      $past(rst_i) |-> (ctrl_o.gain_5v2 == APDC_RST_AMP[APDC_AMP_GAIN]
         && ctrl_o.mod_64fs == APDC_RST_DAC[APDC_CONVERTER_LOW_POWER]
         && ctrl_o.battery_only && !ctrl_o.amp_dac_en))
      else $error("control outputs not at reset map after reset");

   // ---------------------------------------------------------------
   // Configuration map and rate field
   // ---------------------------------------------------------------
   a_amp_cfg_map: assert property ( // RULE7 RULE8 RULE9
      wr_amp |-> ##2 (ctrl_o.sense_hpf_en == $past(reg_wdata_i[3], 2)
         && ctrl_o.low_emi_edge_rate_select == $past(reg_wdata_i[2], 2)
         && ctrl_o.gain_5v2 == $past(reg_wdata_i[0], 2)))
      else $error("amp config not reflected in controls");
   a_dac_cfg_map: assert property ( // RULE10 RULE11 RULE13 RULE14
      wr_dac |-> ##2 (ctrl_o.converter_highpass_enable_en == $past(reg_wdata_i[5], 2)
         && ctrl_o.mod_64fs == $past(reg_wdata_i[4], 2)
         && ctrl_o.hard_volume == $past(reg_wdata_i[7], 2)
         && ctrl_o.dac_mute == $past(reg_wdata_i[6], 2)))
      else $error("DAC config not reflected in controls");
   a_mute_clear: assert property ( // RULE14
      (wr_dac && !reg_wdata_i[APDC_DAC_MUTE]) |-> ##2 !ctrl_o.dac_mute)
      else $error("mute not released");
   a_rate_reserved: assert property ( // RULE12
      (wr_dac && new_rate > APDC_RATE_MAX) |=>
         $stable(converter_playback_config_r[2:0]))
      else $error("reserved rate code accepted");
   a_rate_legal: assert property ( // RULE12
      ctrl_o.rate_range <= APDC_RATE_MAX)
      else $error("rate range out of legal codes");
   a_rate_accept: assert property ( // RULE12
      (wr_dac && new_rate <= APDC_RATE_MAX) |=>
         converter_playback_config_r[2:0] == $past(new_rate))
      else $error("legal rate code not stored");
   a_dac_upper_taken: assert property ( // RULE13 RULE14
      wr_dac |=>
         converter_playback_config_r[7:3] == $past(reg_wdata_i[7:3]))
      else $error("upper DAC bits not stored");

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   a_read_strobe: assert property (
      reg_rd_i |=> reg_rvalid_o)
      else $error("read strobe without valid");
   a_read_idle: assert property (
      !reg_rd_i |=> (!reg_rvalid_o && reg_rdata_o == 8'h00))
      else $error("read data not cleared when idle");
   a_read_power: assert property ( // RULE5
      (reg_rd_i && reg_addr_i == APDC_OFS_POWER) |=>
         reg_rdata_o == $past(power_down_control_r))
      else $error("power register read mismatch");
   a_read_amp: assert property ( // RULE7
      (reg_rd_i && reg_addr_i == APDC_OFS_AMP) |=>
         reg_rdata_o == $past(amplifier_sense_config_r))
      else $error("amp register read mismatch");
   a_read_dac: assert property ( // RULE12
      (reg_rd_i && reg_addr_i == APDC_OFS_DAC) |=>
         reg_rdata_o == $past(converter_playback_config_r))
      else $error("DAC register read mismatch");
   a_read_unmapped: assert property (
      (reg_rd_i && reg_addr_i > APDC_OFS_DAC) |=> reg_rdata_o == 8'h00)
      else $error("unmapped offset read not zero");

   // ---------------------------------------------------------------
   // Sense strobe
   // ---------------------------------------------------------------
   a_sense_div_gap: assert property ( // RULE6
      (ctrl_r.sense_div == 2'h3 && $stable(ctrl_r.sense_div))
         |-> samp_gap_r <= 4'h8)
      else $error("sense divider gap too long");
   a_sense_quiet_off: assert property ( // RULE1
      !ctrl_r.current_sense_en |=> !sense_sample_o)
      else $error("sense strobe while current sense off");
   a_sense_needs_dac: assert property ( // RULE6
      sense_sample_o |-> $past(dac_sample_i))
      else $error("sense strobe without DAC sample");

   // ---------------------------------------------------------------
   // Cover
   // ---------------------------------------------------------------
   c_leave_pd: cover property (
      wr_power && reg_wdata_i == 8'h00 ##2 ctrl_o.five_level_en);
   c_sense_eighth: cover property (
      ctrl_r.sense_div == 2'h3 && sense_sample_o);
   c_reserved_rate: cover property (wr_dac && new_rate == 3'h7);
   c_read_back: cover property (reg_rd_i && reg_addr_i == APDC_OFS_DAC);
   c_sense_off: cover property (wr_power && reg_wdata_i[APDC_PWR_ISNS]);

endmodule : apdc_regs
`default_nettype wire

// [logic/apdc_sense_rate.sv]
// Sense sample strobe generator: divides the DAC sample strobe.
`timescale 1ns/1ps
`default_nettype none
module apdc_sense_rate
   import apdc_pkg::*;
#(
   parameter int CNT_W = 3
) (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       enable_i,
   input  wire logic       dac_sample_i,
   input  wire logic [1:0] div_i,
   output logic            sense_sample_o
);

   logic [CNT_W-1:0] cnt_r;
   logic             sense_sample_r;

   // Mask of counter bits that must be zero for a sense sample
   function automatic logic [CNT_W-1:0] div_mask(input logic [1:0] d);
      logic [CNT_W-1:0] m;
      m = '0;
      case (d)
         2'h1:    m = 3'h1;
         2'h2:    m = 3'h3;
         2'h3:    m = 3'h7;
         default: m = 3'h0;
      endcase
      return m;
   endfunction : div_mask

   // Counter cleared to zero while disabled so restart phase is known
   always_ff @(posedge clock_i) begin
      if (rst_i || !enable_i) begin
         cnt_r <= '0;
      end else if (dac_sample_i) begin
         cnt_r <= cnt_r + 3'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sense_sample_r <= 1'b0;
      end else begin
         sense_sample_r <= enable_i && dac_sample_i &&
                           ((cnt_r & div_mask(div_i)) == 3'h0); // RULE6
      end
   end

   assign sense_sample_o = sense_sample_r;

endmodule : apdc_sense_rate
`default_nettype wire

// [testbench/apdc_testbench.sv]
// Self-checking bench for the power, sense and DAC configuration registers.
`timescale 1ns/1ps
`default_nettype none
module testbench import apdc_pkg::*;;
   logic        clock_i      = 1'b0;
   logic        rst_i        = 1'b1;
   logic [7:0]  reg_addr_i   = 8'h00;
   logic [7:0]  reg_wdata_i  = 8'h00;
   logic        reg_wr_i     = 1'b0;
   logic        reg_rd_i     = 1'b0;
   logic        dac_sample_i = 1'b0;
   logic [7:0]  reg_rdata_o;
   logic        reg_rvalid_o;
   logic        sense_sample_o;
   apdc_ctrl_s  ctrl_o;
   logic [7:0]  m [3];
   logic [7:0]  a;
   logic [31:0] lfsr = 32'h50b5;
   int          num_errors = 0;
   int          n_tests = 0;
   int          n_sns = 0;
   int          base;

   always #20 clock_i = ~clock_i;

   apdc_regs dut (
      .clock_i        (clock_i),
      .rst_i          (rst_i),
      .reg_addr_i     (reg_addr_i),
      .reg_wdata_i    (reg_wdata_i),
      .reg_wr_i       (reg_wr_i),
      .reg_rd_i       (reg_rd_i),
      .reg_rdata_o    (reg_rdata_o),
      .reg_rvalid_o   (reg_rvalid_o),
      .dac_sample_i   (dac_sample_i),
      .sense_sample_o (sense_sample_o),
      .ctrl_o         (ctrl_o)
   );

   // Counted on the falling edge so one-cycle strobes are never missed
   always @(negedge clock_i) begin
      if (sense_sample_o === 1'b1) n_sns++;
   end

   // ---------------------------------------------------------------
   // Expectation helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt

   function automatic logic [16:0] exp_ctrl(input logic [7:0] p, q, d);
      logic bo;
      bo = p[1] | p[3] | p[0];
      return {~p[4] & ~p[0], ~p[3] & ~p[0], ~p[2] & ~p[0], bo, ~bo,
              q[3], q[2], q[0], d[7:4], d[2:0], q[5:4]};
   endfunction : exp_ctrl

   task automatic chk(input string nm, input logic [16:0] e, g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude

   // ---------------------------------------------------------------
   // Port tasks, entered just after a falling edge
   // ---------------------------------------------------------------
   task automatic upd(input logic [7:0] ad, d);
      // Reserved rate codes leave the old rate in place
      if (ad == 8'h02 && d[2:0] > 3'h4) m[2] = {d[7:3], m[2][2:0]};
      else if (ad < 8'h03) m[ad[1:0]] = d;
   endtask : upd

   task automatic wr(input logic [7:0] ad, d, input logic also_rd = 1'b0);
      logic [7:0] e;
      e = (ad < 8'h03) ? m[ad[1:0]] : 8'h00;
      reg_addr_i = ad;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      reg_rd_i = also_rd;
      @(negedge clock_i);
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      upd(ad, d);
      if (also_rd) chk("old rdata", 17'(e), 17'(reg_rdata_o));
      // Idle edge so the next call never reassigns a strobe in one step
      @(negedge clock_i);
   endtask : wr

   task automatic rd(input logic [7:0] ad);
      logic [7:0] e;
      e = (ad < 8'h03) ? m[ad[1:0]] : 8'h00;
      reg_addr_i = ad;
      reg_rd_i = 1'b1;
      @(negedge clock_i);
      reg_rd_i = 1'b0;
      chk("rvalid", 17'h1, 17'(reg_rvalid_o));
      chk("rdata", 17'(e), 17'(reg_rdata_o));
      @(negedge clock_i);
      chk("rvalid idle", 17'h0, 17'(reg_rvalid_o));
      chk("rdata idle", 17'h0, 17'(reg_rdata_o));
   endtask : rd

   task automatic do_reset();
      rst_i = 1'b1;
      repeat (20) @(negedge clock_i);
      rst_i = 1'b0;
      m[0] = 8'h81;
      m[1] = 8'h09;
      m[2] = 8'h32;
   endtask : do_reset

   task automatic pulses(input int n);
      repeat (n) begin
         dac_sample_i = 1'b1;
         @(negedge clock_i);
         dac_sample_i = 1'b0;
         repeat (2) @(negedge clock_i);
      end
   endtask : pulses

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      @(negedge clock_i);
      do_reset();
      chk("ctrl", exp_ctrl(m[0], m[1], m[2]), ctrl_o);
      for (int i = 0; i < 4; i++) rd(8'(i));
      wr(8'h02, 8'hc5, 1'b1);
      rd(8'h02);
      for (int i = 0; i < 8; i++) begin
         wr(8'h02, {5'h16, 3'(i)});
         rd(8'h02);
         chk("ctrl", exp_ctrl(m[0], m[1], m[2]), ctrl_o);
      end
      repeat (60) begin
         lfsr = nxt(lfsr);
         a = lfsr[10] ? 8'hff : {6'h00, lfsr[9:8]};
         wr(a, lfsr[7:0]);
         rd(a);
         chk("ctrl", exp_ctrl(m[0], m[1], m[2]), ctrl_o);
      end
      wr(8'h00, 8'h00);
      for (int dv = 0; dv < 4; dv++) begin
         wr(8'h01, {2'h0, 2'(dv), 4'h9});
         @(negedge clock_i);
         base = n_sns;
         pulses(16);
         chk("sense pulses", 17'(16 >> dv), 17'(n_sns - base));
      end
      for (int k = 0; k < 2; k++) begin
         wr(8'h00, k ? 8'h01 : 8'h10);
         @(negedge clock_i);
         base = n_sns;
         pulses(8);
         chk("sense off", 17'h0, 17'(n_sns - base));
      end
      do_reset();
      rd(8'h00);
      rd(8'h01);
      chk("ctrl", exp_ctrl(m[0], m[1], m[2]), ctrl_o);
      conclude();
   end

   // Generous bound: the sequence needs well under a thousand cycles
   initial begin
      #(40 * 5000);
      num_errors++;
      $display("[ERR] watchdog expected done seen hang");
      conclude();
   end

endmodule : testbench
`default_nettype wire
